// File: design/motor_regs_pkg.sv
// shared constants, types and decode helpers for the motor register bank
package motor_regs_pkg;

    // bus geometry
    localparam int ADDR_W = 12;
    localparam int DATA_W = 32;

    // clock: 4 ns period
    localparam int CLK_PERIOD_NS = 4;
    localparam int CLK_HZ        = 1_000_000_000 / CLK_PERIOD_NS;

    // register indices; byte address is four times the index
    localparam logic [7:0] IDX_SHUTDOWN_THR  = 8'h8D;
    localparam logic [7:0] IDX_CTRL_VOLT     = 8'h8F;
    localparam logic [7:0] IDX_POS_PRESET    = 8'h90;
    localparam logic [7:0] IDX_POS_PRESET_HI = 8'h91;
    localparam logic [7:0] IDX_SPEED_CODE    = 8'h92;
    localparam logic [7:0] IDX_RESP_DELAY    = 8'h93;
    localparam logic [7:0] IDX_GROUP_IDENTIFIER      = 8'h94;
    localparam logic [7:0] IDX_GROUP_WRITE_SEQUENCE     = 8'h95;
    localparam logic [7:0] IDX_UNIT_ADDR     = 8'h96;
    localparam logic [7:0] IDX_MOTOR_VARIANT = 8'h97;
    localparam logic [7:0] IDX_SERIAL_NUM    = 8'h98;
    localparam logic [7:0] IDX_CHECKSUM_LO   = 8'h9A;
    localparam logic [7:0] IDX_CHECKSUM_HI   = 8'h9B;
    localparam logic [7:0] IDX_HW_REV        = 8'h9C;
    localparam logic [7:0] IDX_BUS_LIMITS    = 8'h9D;
    localparam logic [7:0] IDX_IO_CAP        = 8'h9E;
    localparam logic [7:0] IDX_BOOT_VER      = 8'h9F;
    localparam logic [7:0] IDX_SCRATCH       = 8'hA0;
    localparam logic [7:0] IDX_OPTIONS       = 8'hA5;
    localparam logic [7:0] IDX_FB_NODE       = 8'hA6;
    localparam logic [7:0] IDX_FB_RATE       = 8'hA7;
    localparam logic [7:0] IDX_MODULE_KIND   = 8'hA8;
    localparam logic [7:0] IDX_ENCODER       = 8'hAA;
    localparam logic [7:0] IDX_ENCODER_HI    = 8'hAB;

    // values after reset, plus the upper limits and the unused code of the settings
    localparam logic [15:0] RST_SHUTDOWN_THR = 16'h06AE;
    localparam logic [2:0]  RST_SPEED_CODE   = 3'h1;
    localparam logic [7:0]  RST_RESP_DELAY   = 8'h0F;
    localparam logic [7:0]  RST_GROUP_IDENTIFIER     = 8'h00;
    localparam logic [7:0]  RST_UNIT_ADDR    = 8'hFE;
    localparam logic [7:0]  MAX_UNIT_ADDR    = 8'hFE;
    localparam logic [6:0]  RST_FB_NODE      = 7'h05;
    localparam logic [3:0]  RST_FB_RATE      = 4'h2;
    localparam logic [3:0]  MAX_FB_RATE      = 4'h8;
    localparam logic [3:0]  UNUSED_FB_RATE   = 4'h1;

    // fast command codes that load the position preset
    localparam logic [7:0] CMD_PRESET_ABS = 8'h17;
    localparam logic [7:0] CMD_PRESET_REL = 8'h18;

    // group-write telegram as handed over by the serial decoder
    typedef struct packed {
        logic       valid;
        logic [7:0] group;
        logic [7:0] seq;
    } telegram_s;

    // position preset order towards the motion core
    typedef struct packed {
        logic        load;
        logic        relative;
        logic [31:0] value;
    } preset_cmd_s;

    // serial speed in baud for each code
    function automatic logic [31:0] baud_of(input logic [2:0] code);
        unique case (code)
            3'h0: return 32'h0000_2580;
            3'h1: return 32'h0000_4B00;
            3'h2: return 32'h0000_9600;
            3'h3: return 32'h0000_E100;
            3'h4: return 32'h0001_C200;
            3'h5: return 32'h0003_8400;
            3'h6: return 32'h0007_0800;
            3'h7: return 32'h000E_1000;
        endcase
    endfunction

    // fieldbus codes 0 and 2..8 are defined, 1 is not
    function automatic logic fb_rate_ok(input logic [3:0] code);
        return (code <= MAX_FB_RATE) && (code != UNUSED_FB_RATE);
    endfunction

endpackage

// File: design/motor_comm_identity_regs.sv
// register bank for supply, serial, fieldbus and identity settings of a motor controller
//
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module motor_comm_identity_regs
    import motor_regs_pkg::*;
#(
    parameter int          CLK_FREQ       = CLK_HZ,
    parameter logic [7:0]  MOTOR_VARIANT  = 8'hC8,          // arbitrary value
    parameter logic [31:0] SERIAL_NUMBER  = 32'h0000_0001,  // arbitrary value
    parameter logic [15:0] CHECKSUM_LO    = 16'h1234,       // arbitrary value
    parameter logic [15:0] CHECKSUM_HI    = 16'h5678,       // arbitrary value
    parameter logic [15:0] HW_REVISION    = 16'h0010,       // arbitrary value
    parameter logic [15:0] BOOT_VERSION   = 16'h0010,       // arbitrary value
    parameter logic [15:0] BUS_VOLT_LIMIT = 16'h0050,
    parameter logic [15:0] FULL_SCALE_MA  = 16'h1770,
    parameter logic [15:0] IO_MASK        = 16'h00FF,
    parameter logic [15:0] MAX_CURRENT    = 16'h05FC,
    parameter logic [15:0] OPTION_BITS    = 16'h0101
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic [DATA_W-1:0] pwdata,
    output logic      [DATA_W-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic              tx_request,
    output logic                   tx_go,
    output logic      [31:0]       serial_bit_cycles,
    input  wire telegram_s         multicast_write_telegram,
    output logic                   group_hit,
    output logic      [7:0]        unit_address,
    input  wire logic [15:0]       control_supply_input,
    output logic                   supply_shutdown,
    input  wire logic [15:0]       bus_voltage,
    output logic                   bus_overvoltage,
    input  wire logic              fast_command_valid,
    input  wire logic [7:0]        fast_command,
    output preset_cmd_s            position_load,
    output logic      [6:0]        fieldbus_node_id,
    output logic      [3:0]        fieldbus_rate_code,
    input  wire logic [7:0]        attached_module_input,
    input  wire logic              encoder_step,
    input  wire logic              encoder_down,
    output logic      [31:0]       external_encoder_count
);

    typedef enum logic [0:0] {DELAY_IDLE, DELAY_RUN} delay_state_e;

    // stored settings
    logic [15:0]  supply_shutdown_threshold;
    logic [31:0]  position_preset;
    logic [2:0]   serial_speed_code;
    logic [7:0]   response_delay;
    logic [7:0]   group_identifier;
    logic [7:0]   group_write_sequence;
    logic [31:0]  volatile_scratch;
    logic [7:0]   attached_module_kind;
    logic [15:0]  control_voltage_measured;

    // response delay engine
    delay_state_e delay_state;
    delay_state_e next_delay_state;
    logic [31:0]  bit_cnt;
    logic [7:0]   bits_left;

    // bit period in clock cycles for a speed code, folded to constants
    function automatic logic [31:0] cycles_of(input logic [2:0] code);
        unique case (code)
            3'h0: return 32'(CLK_FREQ / baud_of(3'h0));
            3'h1: return 32'(CLK_FREQ / baud_of(3'h1));
            3'h2: return 32'(CLK_FREQ / baud_of(3'h2));
            3'h3: return 32'(CLK_FREQ / baud_of(3'h3));
            3'h4: return 32'(CLK_FREQ / baud_of(3'h4));
            3'h5: return 32'(CLK_FREQ / baud_of(3'h5));
            3'h6: return 32'(CLK_FREQ / baud_of(3'h6));
            3'h7: return 32'(CLK_FREQ / baud_of(3'h7));
        endcase
    endfunction

    // apb decode: word aligned, index in bits 9:2, upper bits must be zero
    wire [7:0] idx       = paddr[9:2];
    wire       addr_ok   = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
    wire       setup     = psel && !penable && !pready;
    wire       wr_fire   = psel && penable && pready && pwrite && addr_ok;
    wire       wr_thr    = wr_fire && (idx == IDX_SHUTDOWN_THR);
    wire       wr_preset = wr_fire && (idx == IDX_POS_PRESET);
    wire       wr_speed  = wr_fire && (idx == IDX_SPEED_CODE);
    wire       wr_delay  = wr_fire && (idx == IDX_RESP_DELAY);
    wire       wr_group  = wr_fire && (idx == IDX_GROUP_IDENTIFIER);
    wire       wr_unit   = wr_fire && (idx == IDX_UNIT_ADDR);
    wire       wr_scr    = wr_fire && (idx == IDX_SCRATCH);
    wire       wr_node   = wr_fire && (idx == IDX_FB_NODE);
    wire       wr_rate   = wr_fire && (idx == IDX_FB_RATE);
    wire       wr_enc    = wr_fire && (idx == IDX_ENCODER);

    // every printed index, reserved words included, is mapped
    wire mapped = addr_ok && ((idx >= IDX_SHUTDOWN_THR && idx <= IDX_SERIAL_NUM)
                  || (idx >= IDX_CHECKSUM_LO && idx <= IDX_SCRATCH)
                  || (idx >= IDX_OPTIONS && idx <= IDX_MODULE_KIND)
                  || idx == IDX_ENCODER || idx == IDX_ENCODER_HI)
                  && idx != 8'h8E;

    // read selection; reserved and gaps read zero
    wire [31:0] rd_word =
        (idx == IDX_SHUTDOWN_THR)  ? {16'h0000, supply_shutdown_threshold} :
        (idx == IDX_CTRL_VOLT)     ? {16'h0000, control_voltage_measured} :
        (idx == IDX_POS_PRESET)    ? position_preset :
        (idx == IDX_SPEED_CODE)    ? {29'h0, serial_speed_code} :
        (idx == IDX_RESP_DELAY)    ? {24'h0, response_delay} :
        (idx == IDX_GROUP_IDENTIFIER)      ? {24'h0, group_identifier} :
        (idx == IDX_GROUP_WRITE_SEQUENCE)     ? {24'h0, group_write_sequence} :
        (idx == IDX_UNIT_ADDR)     ? {24'h0, unit_address} :
        (idx == IDX_MOTOR_VARIANT) ? {24'h0, MOTOR_VARIANT} :
        (idx == IDX_SERIAL_NUM)    ? SERIAL_NUMBER :
        (idx == IDX_CHECKSUM_LO)   ? {16'h0000, CHECKSUM_LO} :
        (idx == IDX_CHECKSUM_HI)   ? {16'h0000, CHECKSUM_HI} :
        (idx == IDX_HW_REV)        ? {16'h0000, HW_REVISION} :
        (idx == IDX_BUS_LIMITS)    ? {FULL_SCALE_MA, BUS_VOLT_LIMIT} :
        (idx == IDX_IO_CAP)        ? {MAX_CURRENT, IO_MASK} :
        (idx == IDX_BOOT_VER)      ? {16'h0000, BOOT_VERSION} :
        (idx == IDX_SCRATCH)       ? volatile_scratch :
        (idx == IDX_OPTIONS)       ? {16'h0000, OPTION_BITS} :
        (idx == IDX_FB_NODE)       ? {25'h0, fieldbus_node_id} :
        (idx == IDX_FB_RATE)       ? {28'h0, fieldbus_rate_code} :
        (idx == IDX_MODULE_KIND)   ? {24'h0, attached_module_kind} :
        (idx == IDX_ENCODER)       ? external_encoder_count :
        32'h0000_0000;

    // apb answer: one wait-free access phase, data latched in setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= setup;
            prdata  <= (setup && addr_ok) ? rd_word : 32'h0000_0000;
            pslverr <= setup && !mapped;
        end
    end

    // supply monitoring settings and sample of the converter result
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_shutdown_threshold <= RST_SHUTDOWN_THR;
            control_voltage_measured  <= 16'h0000;
        end else begin
            if (wr_thr) begin
                supply_shutdown_threshold <= pwdata[15:0];
            end
            control_voltage_measured <= control_supply_input;
        end
    end

    // shutdown flag compares the latest supply sample, overvoltage flag the live bus voltage
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            supply_shutdown <= 1'b0;
            bus_overvoltage <= 1'b0;
        end else begin
            supply_shutdown <= control_voltage_measured < supply_shutdown_threshold;
            bus_overvoltage <= bus_voltage > BUS_VOLT_LIMIT;
        end
    end

    // serial port settings; out-of-range unit address writes are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_speed_code <= RST_SPEED_CODE;
            response_delay    <= RST_RESP_DELAY;
            group_identifier  <= RST_GROUP_IDENTIFIER;
            unit_address      <= RST_UNIT_ADDR;
        end else begin
            if (wr_speed) begin
                serial_speed_code <= pwdata[2:0];
            end
            if (wr_delay && pwdata[7:0] != 8'h00) begin
                response_delay <= pwdata[7:0];
            end
            if (wr_group) begin
                group_identifier <= pwdata[7:0];
            end
            if (wr_unit && pwdata[7:0] <= MAX_UNIT_ADDR) begin
                unit_address <= pwdata[7:0];
            end
        end
    end

    // bit period follows the speed code one cycle later
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            serial_bit_cycles <= 32'h0000_0000;
        end else begin
            serial_bit_cycles <= cycles_of(serial_speed_code);
        end
    end

    // group-write telegram: match and remember its sequence number
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            group_hit            <= 1'b0;
            group_write_sequence <= 8'h00;
        end else begin
            group_hit <= multicast_write_telegram.valid
                         && multicast_write_telegram.group == group_identifier;
            if (multicast_write_telegram.valid) begin
                group_write_sequence <= multicast_write_telegram.seq;
            end
        end
    end

    // response delay: a request made while waiting is absorbed
    always_comb begin
        next_delay_state = delay_state;
        unique case (delay_state)
            DELAY_IDLE: if (tx_request) next_delay_state = DELAY_RUN;
            DELAY_RUN:  if (bits_left == 8'h01 && bit_cnt == 32'h0) next_delay_state = DELAY_IDLE;
        endcase
    end

    // counts whole bit times; speed is taken again at the start of each bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            delay_state <= DELAY_IDLE;
            bit_cnt     <= 32'h0000_0000;
            bits_left   <= 8'h00;
            tx_go       <= 1'b0;
        end else begin
            delay_state <= next_delay_state;
            tx_go       <= 1'b0;
            if (delay_state == DELAY_IDLE) begin
                bits_left <= response_delay;
                bit_cnt   <= serial_bit_cycles - 32'h1;
            end else if (bit_cnt != 32'h0) begin
                bit_cnt <= bit_cnt - 32'h1;
            end else begin
                bit_cnt   <= serial_bit_cycles - 32'h1;
                bits_left <= bits_left - 8'h01;
                tx_go     <= bits_left == 8'h01;
            end
        end
    end

    // position preset and its load order on fast commands
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            position_preset <= 32'h0000_0000;
            position_load   <= '0;
        end else begin
            if (wr_preset) begin
                position_preset <= pwdata;
            end
            position_load.load     <= fast_command_valid
                                      && (fast_command == CMD_PRESET_ABS
                                      || fast_command == CMD_PRESET_REL);
            position_load.relative <= fast_command == CMD_PRESET_REL;
            position_load.value    <= position_preset;
        end
    end

    // scratch word, fieldbus settings and module kind sample
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            volatile_scratch     <= 32'h0000_0000;
            fieldbus_node_id     <= RST_FB_NODE;
            fieldbus_rate_code   <= RST_FB_RATE;
            attached_module_kind <= 8'h00;
        end else begin
            if (wr_scr) begin
                volatile_scratch <= pwdata;
            end
            if (wr_node && pwdata[31:7] == '0) begin
                fieldbus_node_id <= pwdata[6:0];
            end
            if (wr_rate && pwdata[31:4] == '0 && fb_rate_ok(pwdata[3:0])) begin
                fieldbus_rate_code <= pwdata[3:0];
            end
            attached_module_kind <= attached_module_input;
        end
    end

    // encoder counter: a write is loaded and a step in that cycle still counts
    wire [31:0] enc_base = wr_enc ? pwdata : external_encoder_count;
    wire [31:0] enc_step = encoder_down ? 32'hFFFF_FFFF : 32'h0000_0001;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            external_encoder_count <= 32'h0000_0000;
        end else begin
            external_encoder_count <= encoder_step ? enc_base + enc_step : enc_base;
        end
    end

endmodule

`default_nettype wire

// File: sim/motor_regs_assertions.sv
// concurrent checks on the ports of the motor register bank
`timescale 1ns/1ps
`default_nettype none
module motor_regs_assertions
    import motor_regs_pkg::*;
#(
    parameter logic [15:0] BUS_VOLT_LIMIT = 16'h0050
) (
    input  wire logic              pclk,
    input  wire logic              presetn,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ADDR_W-1:0] paddr,
    input  wire logic              pready,
    input  wire logic              pslverr,
    input  wire logic              tx_go,
    input  wire telegram_s         multicast_write_telegram,
    input  wire logic              group_hit,
    input  wire logic [7:0]        unit_address,
    input  wire logic [15:0]       bus_voltage,
    input  wire logic              bus_overvoltage,
    input  wire logic              fast_command_valid,
    input  wire logic [7:0]        fast_command,
    input  wire preset_cmd_s       position_load,
    input  wire logic [3:0]        fieldbus_rate_code,
    input  wire logic              encoder_step,
    input  wire logic              encoder_down,
    input  wire logic [31:0]       external_encoder_count
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // a transfer is a setup cycle, then one access cycle that the slave ends
    sequence s_setup; psel && !penable; endsequence
    sequence s_access; psel && penable && pready; endsequence
    a_setup_then_ready: assert property (s_setup |=> s_access)
        else $error("access not answered after setup");
    a_ready_one_cycle: assert property (pready |=> !pready)
        else $error("ready held too long");
    a_unmapped_error: assert property (pready && paddr == 12'h238 |-> pslverr)
        else $error("unmapped word without error");
    a_reply_pulse: assert property (tx_go |=> !tx_go)
        else $error("reply start longer than one cycle");
    a_hit_has_cause: assert property (group_hit |-> $past(multicast_write_telegram.valid))
        else $error("group hit without telegram");
    a_preset_abs: assert property (fast_command_valid && fast_command == CMD_PRESET_ABS
        |=> position_load.load && !position_load.relative) else $error("absolute preset missed");
    a_preset_rel: assert property (fast_command_valid && fast_command == CMD_PRESET_REL
        |=> position_load.load && position_load.relative) else $error("relative preset missed");
    a_load_has_cause: assert property (position_load.load |-> $past(fast_command_valid))
        else $error("position load without command");
    a_overvolt_track: assert property (1'b1 |=>
        bus_overvoltage == ($past(bus_voltage) > BUS_VOLT_LIMIT)) else $error("overvoltage wrong");
    a_encoder_up: assert property (encoder_step && !encoder_down && !(psel && pwrite)
        |=> external_encoder_count == $past(external_encoder_count) + 32'h1)
        else $error("encoder did not count up");
    a_addr_range: assert property (unit_address <= MAX_UNIT_ADDR)
        else $error("unit address out of range");
    a_rate_legal: assert property (fieldbus_rate_code <= 4'h8 && fieldbus_rate_code != 4'h1)
        else $error("fieldbus rate code illegal");
endmodule
bind motor_comm_identity_regs motor_regs_assertions #(.BUS_VOLT_LIMIT(BUS_VOLT_LIMIT)) chk (.*);
`default_nettype wire

// File: sim/serial_host_model.sv
// serial decoder side: telegrams, fast commands and reply requests
`timescale 1ns/1ps
`default_nettype none
module serial_host_model
    import motor_regs_pkg::*;
(
    input  wire logic  pclk,
    input  wire logic  tx_go,
    input  wire logic  group_hit,
    input  wire preset_cmd_s position_load,
    output logic       tx_request = 1'b0,
    output telegram_s  multicast_write_telegram = '0,
    output logic       fast_command_valid = 1'b0,
    output logic [7:0] fast_command = 8'h00
);
    // idle fields carry inverted leftovers so a stale value cannot pass
    task automatic send(input logic [7:0] g, input logic [7:0] s, output logic hit);
        multicast_write_telegram <= {1'b1, g, s};
        @(posedge pclk);
        multicast_write_telegram <= {1'b0, ~g, ~s};
        @(posedge pclk);
        hit = group_hit;
    endtask
    // load order is visible the cycle after the command is taken
    task automatic fast(input logic [7:0] c, output preset_cmd_s p);
        fast_command_valid <= 1'b1;
        fast_command <= c;
        @(posedge pclk);
        fast_command_valid <= 1'b0;
        fast_command <= ~c;
        @(posedge pclk);
        p = position_load;
    endtask
    // counts cycles until the block lets the reply go; bounded against a hang
    task automatic respond(output int n);
        tx_request <= 1'b1;
        @(posedge pclk);
        tx_request <= 1'b0;
        n = 0;
        while (tx_go !== 1'b1 && n < 400) begin
            @(posedge pclk);
            n++;
        end
    endtask
endmodule
`default_nettype wire

// File: sim/motor_comm_identity_regs_tb.sv
// self-checking bench for the motor register bank
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, x, g) begin num_checks++; if ((g) !== (x)) begin miscompares++; \
    $display("unexpected %s exp %h got %h", nm, x, g); end end
module motor_comm_identity_regs_tb
    import motor_regs_pkg::*;
;
    localparam int FREQ = 9216000; // short bit times: ten cycles at the top speed
    logic              pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [ADDR_W-1:0] paddr = '0;
    logic [DATA_W-1:0] pwdata = '0;
    logic              encoder_step = 1'b0, encoder_down = 1'b0;
    logic [15:0]       control_supply_input = 16'h0800, bus_voltage = 16'h0030;
    logic [7:0]        attached_module_input = 8'h00;
    wire logic [31:0]  prdata, serial_bit_cycles, external_encoder_count;
    wire logic         pready, pslverr, tx_go, group_hit, supply_shutdown, bus_overvoltage;
    wire logic         tx_request, fast_command_valid;
    wire logic [7:0]   unit_address, fast_command;
    wire logic [6:0]   fieldbus_node_id;
    wire logic [3:0]   fieldbus_rate_code;
    wire telegram_s    multicast_write_telegram;
    wire preset_cmd_s  position_load;
    int                miscompares = 0, num_checks = 0, cyc = 0, n, i;
    logic [31:0]       v;
    logic              e;
    preset_cmd_s       p;
    int                bauds [8] = '{9600, 19200, 38400, 57600, 115200, 230400, 460800, 921600};
    // index and value after reset, identity words as built
    logic [39:0]       tbl [22] = '{{8'h8D, 32'h6AE}, {8'h90, 32'h0}, {8'h91, 32'h0},
        {8'h92, 32'h1}, {8'h93, 32'hF}, {8'h94, 32'h0}, {8'h96, 32'hFE}, {8'h97, 32'hC8},
        {8'h98, 32'h1}, {8'h9A, 32'h1234}, {8'h9B, 32'h5678}, {8'h9C, 32'h10},
        {8'h9D, 32'h17700050}, {8'h9E, 32'h05FC00FF}, {8'h9F, 32'h10}, {8'hA0, 32'h0},
        {8'hA5, 32'h101}, {8'hA6, 32'h5}, {8'hA7, 32'h2}, {8'hA8, 32'h0}, {8'hAA, 32'h0},
        {8'hAB, 32'h0}};

    motor_comm_identity_regs #(.CLK_FREQ(FREQ)) dut (.*);
    serial_host_model host (.*);

    always #2 pclk = ~pclk;
    // hang guard, far above the few hundred cycles the run needs
    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            miscompares++;
            complete_run();
        end
    end
    // one bus transfer; the request stands until ready is sampled high
    task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {2'b00, idx, 2'b00};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // no wait count assumed; only the hang guard ends a stuck access
        do begin
            @(posedge pclk);
        end while (pready !== 1'b1);
        v = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [7:0] idx, input logic [31:0] d);
        apb(1'b1, idx, d);
    endtask
    task automatic rdc(input logic [7:0] idx, input logic [31:0] x);
        apb(1'b0, idx, 32'h0);
        `CHK($sformatf("reg %h", idx), x, v)
    endtask
    task automatic step(input logic dn);
        encoder_step <= 1'b1;
        encoder_down <= dn;
        @(posedge pclk);
        encoder_step <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic complete_run();
        if (miscompares == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    initial begin
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        for (i = 0; i < 22; i++) rdc(tbl[i][39:32], tbl[i][31:0]);
        // read-only and reserved words must shrug off writes
        wr(IDX_MOTOR_VARIANT, 32'h0);
        wr(IDX_ENCODER_HI, 32'hFFFFFFFF);
        rdc(IDX_MOTOR_VARIANT, 32'hC8);
        rdc(IDX_ENCODER_HI, 32'h0);
        `CHK("reserved error", 1'b0, e)
        apb(1'b0, 8'h8E, 32'h0);
        `CHK("unmapped error", 1'b1, e)
        `CHK("unmapped data", 32'h0, v)
        // out-of-range settings dropped, the edge values kept
        wr(IDX_UNIT_ADDR, 32'hFF);
        rdc(IDX_UNIT_ADDR, 32'hFE);
        wr(IDX_UNIT_ADDR, 32'h0);
        `CHK("unit address", 8'h00, unit_address)
        wr(IDX_FB_NODE, 32'h80);
        rdc(IDX_FB_NODE, 32'h5);
        wr(IDX_FB_NODE, 32'h7F);
        rdc(IDX_FB_NODE, 32'h7F);
        `CHK("node id port", 7'h7F, fieldbus_node_id)
        wr(IDX_FB_RATE, 32'h1);
        wr(IDX_FB_RATE, 32'h9);
        rdc(IDX_FB_RATE, 32'h2);
        wr(IDX_FB_RATE, 32'h8);
        rdc(IDX_FB_RATE, 32'h8);
        wr(IDX_RESP_DELAY, 32'h0);
        rdc(IDX_RESP_DELAY, 32'hF);
        wr(IDX_SCRATCH, 32'hA5A55A5A);
        rdc(IDX_SCRATCH, 32'hA5A55A5A);
        // supply one step under the threshold, then at it
        control_supply_input <= 16'h06AD;
        repeat (3) @(posedge pclk);
        `CHK("shutdown low", 1'b1, supply_shutdown)
        rdc(IDX_CTRL_VOLT, 32'h6AD);
        control_supply_input <= 16'h06AE;
        bus_voltage <= 16'h0051;
        attached_module_input <= 8'h2C;
        repeat (3) @(posedge pclk);
        `CHK("shutdown at limit", 1'b0, supply_shutdown)
        `CHK("overvoltage", 1'b1, bus_overvoltage)
        rdc(IDX_MODULE_KIND, 32'h2C);
        for (i = 0; i < 8; i++) begin
            wr(IDX_SPEED_CODE, 32'(i));
            @(posedge pclk); // the period register follows the code one edge later
            `CHK("bit cycles", 32'(FREQ / bauds[i]), serial_bit_cycles)
        end
        // two bit times at ten cycles a bit
        wr(IDX_RESP_DELAY, 32'h2);
        host.respond(n);
        `CHK("reply wait", 1'b1, n >= 18 && n <= 24)
        wr(IDX_GROUP_IDENTIFIER, 32'h33);
        host.send(8'h33, 8'h44, e);
        `CHK("group hit", 1'b1, e)
        rdc(IDX_GROUP_WRITE_SEQUENCE, 32'h44);
        host.send(8'h34, 8'h45, e);
        `CHK("group miss", 1'b0, e)
        rdc(IDX_GROUP_WRITE_SEQUENCE, 32'h45);
        wr(IDX_POS_PRESET, 32'hFFFFFFF0);
        host.fast(CMD_PRESET_ABS, p);
        `CHK("absolute load", {1'b1, 1'b0, 32'hFFFFFFF0}, p)
        host.fast(CMD_PRESET_REL, p);
        `CHK("relative load", {1'b1, 1'b1, 32'hFFFFFFF0}, p)
        // encoder crosses the signed top in both directions
        wr(IDX_ENCODER, 32'h7FFFFFFE);
        step(1'b0);
        step(1'b0);
        step(1'b1);
        rdc(IDX_ENCODER, 32'h7FFFFFFF);
        complete_run();
    end
endmodule
`default_nettype wire
